// ### hw/dmmd_pkg.sv
package dmmd_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TERM_BAUD = 9600;
	localparam int unsigned HOST_BAUD_MIN = 300;
	localparam logic [2:0] HOST_SEL_MAX = 3'h6;
	localparam logic [17:0] TERM_DIV = 18'(CLK_HZ / TERM_BAUD);

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [13:0] A_IO_END = 14'h001F;
	localparam logic [13:0] A_SER_BASE = 14'h0020;
	localparam logic [13:0] A_SER_END = 14'h0027;
	localparam logic [13:0] A_MAP = 14'h0050;
	localparam logic [13:0] A_SCR_END = 14'h00FF;
	localparam logic [13:0] A_STK = 14'h0100;
	localparam logic [13:0] A_LOW_END = 14'h017F;
	localparam logic [13:0] A_ROM_BASE = 14'h0180;
	localparam logic [13:0] A_RAM28 = 14'h0080;
	localparam logic [13:0] A_P28_END = 14'h08FF;
	localparam logic [13:0] A_P28_TOP = 14'h1FF0;
	localparam logic [13:0] A_OPT8 = 14'h1FDF;
	localparam logic [13:0] A_BANK2 = 14'h2000;
	localparam logic [13:0] A_MRSV16_END = 14'h217F;
	localparam logic [13:0] A_OPT16 = 14'h3FDF;
	localparam logic [1:0] SER_DATA = 2'h0;
	localparam logic [1:0] SER_STAT = 2'h1;
	localparam logic [1:0] SER_CTRL = 2'h2;

	// ----------------------------------------------------------------
	// Map-select register fields and sequencing
	// ----------------------------------------------------------------
	localparam int unsigned MB_PERM = 0;
	localparam int unsigned MB_TEMP = 1;
	localparam int unsigned MB_PROT = 2;
	localparam int unsigned MB_BKPT = 3;
	localparam int unsigned MB_TRACE = 4;
	localparam int unsigned MB_ABORT = 5;
	localparam logic [7:0] MAP_RESET = 8'h00;
	localparam logic [7:0] SOFT_TRAP_OPCODE = 8'h83;
	localparam logic [2:0] STACK_PUSHES = 3'h5;
	localparam logic [1:0] TEMP_OPERANDS = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PART_STD40, PART_BIG40, PART_PIN28, PART_PIN28_OPT} dmmd_part_t;
	typedef enum logic [1:0] {TRAP_IDLE, TRAP_FORCE, TRAP_STACK} dmmd_trap_t;
	typedef struct packed {
		logic io;
		logic serial;
		logic map_reg;
		logic scratch;
		logic stack_cap;
		logic mon_rom;
		logic user_ram;
		logic pseudo_rom;
		logic option_reg;
		logic reserved;
	} dmmd_sel_t;

	function automatic logic [17:0] host_div(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > HOST_SEL_MAX) ? HOST_SEL_MAX : sel;
		host_div = 18'(CLK_HZ / (HOST_BAUD_MIN << s));
	endfunction

endpackage

// ### hw/dmmd_decoder.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RQ1] Map-select register at 0050 decodes only in the monitor map.
// [RQ2] Map-select register drives temporary/permanent switching, protection and entry flags.
// [RQ3] Serial adapter 0020-0027 is selected only in the monitor map.
// [RQ4] Monitor ROM is decoded only while the monitor map is in use.
// [RQ5] Monitor map: I/O, serial, reserved, map reg, scratch, stack capture, reserved, ROM.
// [RQ6] Pseudo ROM writes blocked in user execution when write-protect jumper fitted.
// [RQ7] Map-size jumper fitted selects 16K layout; open selects 8K layout.
// [RQ8] 16K user layout: I/O, bank one to 1FFF, bank two, option at 3FDF.
// [RQ9] 28-pin layout: reserved 0050-007F, RAM, pseudo ROM, reserved, top pseudo ROM.
// [RQ10] 40-pin option register and extra RAM decode only for the enlarged part; the 16K option register at 3FDF decodes for either 40-pin part.
// [RQ11] Software starts user code at 0180 when the enlarged-RAM part is fitted.
// [RQ12] Two independent full-duplex channels, own registers and baud generators.
// [RQ13] Terminal channel runs at a fixed baud rate.
// [RQ14] Host channel baud rate is software selectable from 300 to 19200.
// [RQ15] Transparent mode passes characters straight between terminal and host.
// [RQ16] Temporary switch: one access in user space after operands, then back.
// [RQ17] Abort forces trap opcode at fetch, then monitor map after stacking.
// [RQ18] A trap fetched with no breakpoint or abort causes no map switch.
// [RQ19] User reset resets processor, selects user map, ignores breakpoints until fetch.
// [RQ20] Chip selects come from address, map, jumper and part configuration.
module dmmd_decoder (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic bus_valid,
	input wire logic bus_wr,
	input wire logic instruction_fetch_strobe,
	input wire logic [13:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic map_size_jumper,
	input wire logic write_protect_jumper,
	input wire logic [1:0] part_cfg,
	input wire logic abort_switch,
	input wire logic user_reset_switch,
	input wire logic breakpoint_hit,
	input wire logic term_rxd,
	input wire logic host_rxd,
	output var dmmd_pkg::dmmd_sel_t sel_q,
	output logic prom_we_q,
	output logic [7:0] rdata_q,
	output logic rdata_en_q,
	output logic [7:0] trap_data_q,
	output logic trap_data_en_q,
	output logic mcu_reset_q,
	output logic user_map_q,
	output logic term_txd_q,
	output logic host_txd_q
);

	// ----------------------------------------------------------------
	// Map state
	// ----------------------------------------------------------------
	logic [7:0] map_q;
	logic perm_arm_q;
	logic temp_arm_q;
	logic temp_fetched_q;
	logic [1:0] temp_cnt_q;
	logic ign_bkpt_q;
	logic abort_pend_q;
	logic trap_is_abort_q;
	logic [2:0] push_cnt_q;
	logic [7:0] stack_q;
	dmmd_pkg::dmmd_trap_t trap_q;

	wire logic acc = clk_en && bus_valid;
	wire logic fetch = acc && instruction_fetch_strobe;
	// The access after the operands of an armed temporary switch runs in user space.
	wire logic temp_now = temp_fetched_q && temp_cnt_q == dmmd_pkg::TEMP_OPERANDS; // see [RQ16]
	wire logic in_user = user_map_q || temp_now;
	wire logic [13:0] a = map_size_jumper ? bus_addr : {1'b0, bus_addr[12:0]}; // see [RQ7]
	wire dmmd_pkg::dmmd_part_t part = dmmd_pkg::dmmd_part_t'(part_cfg);
	wire logic big = part == dmmd_pkg::PART_BIG40;
	wire logic pin28 = part == dmmd_pkg::PART_PIN28 || part == dmmd_pkg::PART_PIN28_OPT;
	wire logic opt_ok = big || part == dmmd_pkg::PART_PIN28_OPT;
	wire logic bkpt_trap = breakpoint_hit && !ign_bkpt_q;
	wire logic trap_go = fetch && user_map_q && (bkpt_trap || abort_pend_q); // see [RQ18]

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic dmmd_pkg::dmmd_sel_t decode(input logic [13:0] ad, input logic usr);
		dmmd_pkg::dmmd_sel_t s;
		s = '0;
		if (ad <= dmmd_pkg::A_IO_END)
			s.io = 1'b1;
		else if (!usr)
		begin
			// Serial adapter, map register and ROM exist only on the monitor side.
			if (ad <= dmmd_pkg::A_SER_END) s.serial = 1'b1; // see [RQ3]
			else if (ad < dmmd_pkg::A_MAP) s.reserved = 1'b1; // see [RQ5]
			else if (ad == dmmd_pkg::A_MAP) s.map_reg = 1'b1; // see [RQ1]
			else if (ad <= dmmd_pkg::A_SCR_END) s.scratch = 1'b1;
			else if (ad == dmmd_pkg::A_STK) s.stack_cap = 1'b1;
			else if (ad < dmmd_pkg::A_ROM_BASE) s.reserved = 1'b1;
			else if (ad >= dmmd_pkg::A_BANK2 && ad <= dmmd_pkg::A_MRSV16_END) s.reserved = 1'b1;
			else s.mon_rom = 1'b1; // see [RQ4]
		end
		else if (pin28)
		begin
			if (ad < dmmd_pkg::A_MAP) s.pseudo_rom = 1'b1; // see [RQ9]
			else if (ad < dmmd_pkg::A_RAM28) s.reserved = 1'b1;
			else if (ad <= dmmd_pkg::A_SCR_END) s.user_ram = 1'b1;
			else if (ad <= dmmd_pkg::A_P28_END) s.pseudo_rom = 1'b1;
			else if (ad == dmmd_pkg::A_OPT8 && opt_ok) s.option_reg = 1'b1;
			else if (ad < dmmd_pkg::A_P28_TOP) s.reserved = 1'b1;
			else s.pseudo_rom = 1'b1;
		end
		else
		begin
			if (ad >= dmmd_pkg::A_MAP && ad <= dmmd_pkg::A_SCR_END) s.user_ram = 1'b1;
			else if (ad > dmmd_pkg::A_SCR_END && ad <= dmmd_pkg::A_LOW_END && big) s.user_ram = 1'b1; // see [RQ10]
			else if (map_size_jumper && ad == dmmd_pkg::A_OPT16) s.option_reg = 1'b1; // see [RQ8]
			else if (!map_size_jumper && ad == dmmd_pkg::A_OPT8 && big) s.option_reg = 1'b1; // see [RQ10]
			else s.pseudo_rom = 1'b1;
		end
		decode = s;
	endfunction

	wire dmmd_pkg::dmmd_sel_t sel_d = decode(a, in_user); // see [RQ20]
	wire logic map_wr = acc && bus_wr && sel_d.map_reg;
	wire logic stk_wr = acc && bus_wr && sel_d.stack_cap;
	// Protection: the jumper guards user execution, the protect bit guards monitor pokes.
	wire logic prom_block = (user_map_q && write_protect_jumper) || (temp_now && map_q[dmmd_pkg::MB_PROT]); // see [RQ6]
	wire logic [7:0] ser_rd;
	wire logic [7:0] own_rd = sel_d.map_reg ? {map_q[7:1], user_map_q} : sel_d.stack_cap ? stack_q : ser_rd;

	// ----------------------------------------------------------------
	// Bus-side outputs, one cycle behind the access
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			sel_q <= '0;
			prom_we_q <= 1'b0;
			rdata_q <= 8'h00;
			rdata_en_q <= 1'b0;
			stack_q <= 8'h00;
		end
		else if (clk_en)
		begin
			sel_q <= bus_valid ? sel_d : '0;
			prom_we_q <= acc && bus_wr && sel_d.pseudo_rom && !prom_block;
			rdata_en_q <= acc && !bus_wr && (sel_d.map_reg || sel_d.stack_cap || sel_d.serial);
			rdata_q <= own_rd;
			if (stk_wr)
				stack_q <= bus_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Map switching, trap entry and user reset
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			map_q <= dmmd_pkg::MAP_RESET;
			user_map_q <= 1'b0;
			perm_arm_q <= 1'b0;
			temp_arm_q <= 1'b0;
			temp_fetched_q <= 1'b0;
			temp_cnt_q <= 2'h0;
			ign_bkpt_q <= 1'b0;
			abort_pend_q <= 1'b0;
			trap_is_abort_q <= 1'b0;
			push_cnt_q <= 3'h0;
			trap_q <= dmmd_pkg::TRAP_IDLE;
			trap_data_q <= 8'h00;
			trap_data_en_q <= 1'b0;
			mcu_reset_q <= 1'b0;
		end
		else if (clk_en)
		begin
			mcu_reset_q <= user_reset_switch;
			trap_data_en_q <= trap_go;
			trap_data_q <= trap_go ? dmmd_pkg::SOFT_TRAP_OPCODE : 8'h00; // see [RQ17]
			if (map_wr)
			begin
				map_q <= bus_wdata;
				perm_arm_q <= bus_wdata[dmmd_pkg::MB_PERM]; // see [RQ2]
				temp_arm_q <= bus_wdata[dmmd_pkg::MB_TEMP];
				temp_fetched_q <= 1'b0;
				temp_cnt_q <= 2'h0;
			end
			// Abort only acts while user code runs; in the monitor it is dropped.
			if (abort_switch && user_map_q)
				abort_pend_q <= 1'b1;
			if (user_reset_switch)
			begin
				user_map_q <= 1'b1; // see [RQ19]
				ign_bkpt_q <= 1'b1;
				abort_pend_q <= 1'b0;
				perm_arm_q <= 1'b0;
				temp_arm_q <= 1'b0;
				trap_q <= dmmd_pkg::TRAP_IDLE;
			end
			else
			begin
				if (fetch)
					ign_bkpt_q <= 1'b0;
				// The return opcode is fetched in the monitor map; stack pulls follow in user space.
				if (perm_arm_q && fetch && !user_map_q)
				begin
					user_map_q <= 1'b1;
					perm_arm_q <= 1'b0;
				end
				if (temp_arm_q && !temp_fetched_q && fetch)
					temp_fetched_q <= 1'b1;
				else if (temp_fetched_q && acc && !map_wr)
				begin
					if (temp_now)
					begin
						temp_arm_q <= 1'b0; // see [RQ16]
						temp_fetched_q <= 1'b0;
					end
					else
						temp_cnt_q <= temp_cnt_q + 2'h1;
				end
				case (trap_q)
					dmmd_pkg::TRAP_IDLE:
					begin
						if (trap_go)
						begin
							trap_q <= dmmd_pkg::TRAP_STACK;
							trap_is_abort_q <= abort_pend_q;
							abort_pend_q <= 1'b0;
							push_cnt_q <= 3'h0;
						end
					end
					dmmd_pkg::TRAP_STACK:
					begin
						// The map switches back only once the user registers are stacked.
						if (acc && bus_wr)
						begin
							push_cnt_q <= push_cnt_q + 3'h1;
							if (push_cnt_q == dmmd_pkg::STACK_PUSHES - 3'h1)
							begin
								user_map_q <= 1'b0; // see [RQ17]
								trap_q <= dmmd_pkg::TRAP_IDLE;
								if (trap_is_abort_q)
									map_q[dmmd_pkg::MB_ABORT] <= 1'b1;
								else
									map_q[dmmd_pkg::MB_BKPT] <= 1'b1;
							end
						end
					end
					default:
						trap_q <= dmmd_pkg::TRAP_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Dual serial adapter: channel 0 terminal, channel 1 host
	// ----------------------------------------------------------------
	logic [7:0] rx_data_q [2];
	logic [2:0] stat_q [2];
	logic [3:0] ctrl_q [2];
	logic tx_pin [2];
	wire logic rxd [2];
	assign rxd[0] = term_rxd;
	assign rxd[1] = host_rxd;
	wire logic [1:0] reg_off = bus_addr[1:0];
	wire logic ch_sel = bus_addr[2];
	wire logic transparent = ctrl_q[0][3]; // see [RQ15]
	assign ser_rd = !sel_d.serial ? 8'h00 : reg_off == dmmd_pkg::SER_DATA ? rx_data_q[ch_sel] :
		reg_off == dmmd_pkg::SER_STAT ? {5'h00, stat_q[ch_sel]} :
		reg_off == dmmd_pkg::SER_CTRL ? {4'h0, ctrl_q[ch_sel]} : 8'h00;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_ch
			logic [17:0] div;
			logic [17:0] tx_cnt_q;
			logic [17:0] rx_cnt_q;
			logic [9:0] tx_sh_q;
			logic [3:0] tx_bits_q;
			logic [7:0] rx_sh_q;
			logic [3:0] rx_bits_q;
			wire logic hit = acc && sel_d.serial && ch_sel == ch;
			wire logic wr_data = hit && bus_wr && reg_off == dmmd_pkg::SER_DATA;
			wire logic rd_data = hit && !bus_wr && reg_off == dmmd_pkg::SER_DATA;
			// Each channel has its own divider: terminal fixed, host from its control field.
			assign div = (ch == 0) ? dmmd_pkg::TERM_DIV : dmmd_pkg::host_div(ctrl_q[ch][2:0]); // see [RQ13] see [RQ14]
			wire logic rx_done = rx_bits_q == 4'hA && rx_cnt_q == 18'h0;

			// Control register, transmitter and receiver of one channel.
			always_ff @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					ctrl_q[ch] <= 4'h0;
					tx_cnt_q <= 18'h0;
					tx_sh_q <= 10'h3FF;
					tx_bits_q <= 4'h0;
					rx_cnt_q <= 18'h0;
					rx_sh_q <= 8'h00;
					rx_bits_q <= 4'h0;
					rx_data_q[ch] <= 8'h00;
					stat_q[ch] <= 3'h2;
					tx_pin[ch] <= 1'b1;
				end
				else if (clk_en)
				begin
					if (hit && bus_wr && reg_off == dmmd_pkg::SER_CTRL)
						ctrl_q[ch] <= bus_wdata[3:0];
					if (wr_data && tx_bits_q == 4'h0) // see [RQ12]
					begin
						tx_sh_q <= {1'b1, bus_wdata, 1'b0};
						tx_bits_q <= 4'hA;
						tx_cnt_q <= div;
					end
					else if (tx_bits_q != 4'h0)
					begin
						if (tx_cnt_q == 18'h0)
						begin
							tx_sh_q <= {1'b1, tx_sh_q[9:1]};
							tx_bits_q <= tx_bits_q - 4'h1;
							tx_cnt_q <= div;
						end
						else
							tx_cnt_q <= tx_cnt_q - 18'h1;
					end
					// Start edge waits half a bit so every later sample lands mid-bit.
					if (rx_bits_q == 4'h0)
					begin
						if (!rxd[ch])
						begin
							rx_bits_q <= 4'h1;
							rx_cnt_q <= {1'b0, div[17:1]};
						end
					end
					else if (rx_cnt_q == 18'h0)
					begin
						// Step 1 is the start bit, steps 2 to 9 the data bits, step 10 the stop bit.
						if (rx_bits_q == 4'hA)
							rx_bits_q <= 4'h0;
						else
						begin
							if (rx_bits_q != 4'h1)
								rx_sh_q <= {rxd[ch], rx_sh_q[7:1]};
							rx_bits_q <= rx_bits_q + 4'h1;
							rx_cnt_q <= div;
						end
					end
					else
						rx_cnt_q <= rx_cnt_q - 18'h1;
					if (rx_done)
						rx_data_q[ch] <= rx_sh_q;
					// A new character wins over the read that clears the full flag.
					stat_q[ch][0] <= rx_done || (stat_q[ch][0] && !rd_data);
					stat_q[ch][1] <= tx_bits_q == 4'h0 && !wr_data;
					stat_q[ch][2] <= (rx_done && stat_q[ch][0] && !rd_data) || (stat_q[ch][2] && !rd_data);
					tx_pin[ch] <= tx_sh_q[0];
				end
			end
		end
	endgenerate

	// Transparent mode bypasses both transmitters so no character is delayed.
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			term_txd_q <= 1'b1;
			host_txd_q <= 1'b1;
		end
		else if (clk_en)
		begin
			term_txd_q <= transparent ? host_rxd : tx_pin[0]; // see [RQ15]
			host_txd_q <= transparent ? term_rxd : tx_pin[1];
		end
	end

endmodule // dmmd_decoder

`default_nettype wire

// ### testbench/dmmd_decoder_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------
// Port checker for the map decoder
// --------------------------------------------------------------
module dmmd_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic bus_valid,
	input wire logic bus_wr,
	input wire logic instruction_fetch_strobe,
	input wire logic [13:0] bus_addr,
	input wire logic write_protect_jumper,
	input wire logic user_reset_switch,
	input wire dmmd_pkg::dmmd_sel_t sel_q,
	input wire logic prom_we_q,
	input wire logic rdata_en_q,
	input wire logic [7:0] trap_data_q,
	input wire logic trap_data_en_q,
	input wire logic mcu_reset_q,
	input wire logic user_map_q
);
	logic acc;
	logic rd_acc;
	logic fetch_u;
	logic [12:0] a_lo;

	// Bit 13 aliases in the 8K layout, so address checks use bits 12:0 only.
	assign acc = clk_en && bus_valid;
	assign rd_acc = acc && !bus_wr;
	assign fetch_u = acc && instruction_fetch_strobe && user_map_q;
	assign a_lo = bus_addr[12:0];

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_trapped_fetch;
		$past(fetch_u);
	endsequence

	a_sel_onehot: assert property ($past(acc) |-> $onehot(sel_q))
		else $error("decode select not one-hot");
	a_idle_clear: assert property (clk_en && !acc |=> sel_q == '0)
		else $error("select raised without access");
	a_map_reg_addr: assert property (sel_q.map_reg |-> $past(a_lo) == 13'h0050 && !$past(user_map_q))
		else $error("map register selected wrongly");
	a_serial_mon: assert property (sel_q.serial |-> $past(a_lo) >= 13'h0020 && $past(a_lo) <= 13'h0027 && !$past(user_map_q))
		else $error("serial adapter selected wrongly");
	a_rom_mon: assert property (sel_q.mon_rom |-> $past(a_lo) >= 13'h0180 && !$past(user_map_q))
		else $error("monitor rom selected wrongly");
	a_stack_addr: assert property (sel_q.stack_cap |-> $past(a_lo) == 13'h0100 && !$past(user_map_q))
		else $error("stack capture selected wrongly");
	a_prot_block: assert property (user_map_q && write_protect_jumper && acc && bus_wr |=> !prom_we_q)
		else $error("protected write let through");
	a_trap_opcode: assert property (trap_data_en_q |-> (trap_data_q == 8'h83) ##0 s_trapped_fetch)
		else $error("trap opcode without user fetch");
	a_reset_user: assert property (clk_en && user_reset_switch |=> mcu_reset_q && user_map_q)
		else $error("user reset did not take effect");
	a_read_data: assert property (rdata_en_q |-> $past(rd_acc))
		else $error("read data without read access");
endmodule // dmmd_checker

bind dmmd_decoder dmmd_checker dmmd_checker_inst (.core_clk, .reset, .clk_en, .bus_valid, .bus_wr,
	.instruction_fetch_strobe, .bus_addr, .write_protect_jumper, .user_reset_switch, .sel_q,
	.prom_we_q, .rdata_en_q, .trap_data_q, .trap_data_en_q, .mcu_reset_q, .user_map_q);

`default_nettype wire

// ### testbench/dmmd_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none

// --------------------------------------------------------------
// Resident controller bus model
// --------------------------------------------------------------
module dmmd_mcu_model (
	input wire logic core_clk,
	output logic bus_valid,
	output logic bus_wr,
	output logic instruction_fetch_strobe,
	output logic [13:0] bus_addr,
	output logic [7:0] bus_wdata
);
	// Idle bus at time zero.
	initial
	begin
		bus_valid = 1'b0;
		bus_wr = 1'b0;
		instruction_fetch_strobe = 1'b0;
		bus_addr = 14'h0000;
		bus_wdata = 8'h00;
	end

	// One access holds for exactly one cycle; afterwards address and data are
	// inverted so a decoder that samples late sees garbage, not a stale value.
	task automatic access(input logic wr, input logic fetch, input logic [13:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		bus_valid <= 1'b1;
		bus_wr <= wr;
		instruction_fetch_strobe <= fetch;
		bus_addr <= addr;
		bus_wdata <= data;
		@(posedge core_clk);
		bus_valid <= 1'b0;
		bus_wr <= 1'b0;
		instruction_fetch_strobe <= 1'b0;
		bus_addr <= ~addr;
		bus_wdata <= ~data;
		#1;
	endtask
endmodule // dmmd_mcu_model

`default_nettype wire

// ### testbench/dual_memory_map_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module dual_memory_map_decoder_tb_top;
	logic core_clk, reset, map_size_jumper, write_protect_jumper, abort_switch;
	logic user_reset_switch, breakpoint_hit, term_rxd, host_rxd;
	logic bus_valid, bus_wr, instruction_fetch_strobe;
	logic [13:0] bus_addr;
	logic [7:0] bus_wdata, rdata_q, trap_data_q;
	logic [1:0] part_cfg;
	dmmd_pkg::dmmd_sel_t sel_q;
	logic prom_we_q, rdata_en_q, trap_data_en_q, mcu_reset_q, user_map_q, term_txd_q, host_txd_q;
	int mismatches = 0;
	int checks = 0;
	// Decode tables: monitor map in 16K, then user map 16K (0..4) and 28-pin 8K (5..8).
	logic [13:0] mon_a [10] = '{14'h0000, 14'h001F, 14'h0027, 14'h0028, 14'h0050, 14'h0051,
		14'h0100, 14'h0101, 14'h0180, 14'h2000};
	logic [9:0] mon_s [10] = '{10'h200, 10'h200, 10'h100, 10'h001, 10'h080, 10'h040,
		10'h020, 10'h001, 10'h010, 10'h001};
	logic [13:0] usr_a [9] = '{14'h0000, 14'h0050, 14'h2000, 14'h3FDF, 14'h3FE0,
		14'h0060, 14'h0080, 14'h0900, 14'h1FF0};
	logic [9:0] usr_s [9] = '{10'h200, 10'h008, 10'h004, 10'h002, 10'h004,
		10'h001, 10'h008, 10'h001, 10'h004};

	dmmd_mcu_model dmmd_mcu_model_inst (.core_clk(core_clk), .bus_valid(bus_valid), .bus_wr(bus_wr),
		.instruction_fetch_strobe(instruction_fetch_strobe), .bus_addr(bus_addr), .bus_wdata(bus_wdata));

	dmmd_decoder dmmd_decoder_inst (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.bus_valid(bus_valid), .bus_wr(bus_wr), .instruction_fetch_strobe(instruction_fetch_strobe),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .map_size_jumper(map_size_jumper),
		.write_protect_jumper(write_protect_jumper), .part_cfg(part_cfg), .abort_switch(abort_switch),
		.user_reset_switch(user_reset_switch), .breakpoint_hit(breakpoint_hit), .term_rxd(term_rxd),
		.host_rxd(host_rxd), .sel_q(sel_q), .prom_we_q(prom_we_q), .rdata_q(rdata_q),
		.rdata_en_q(rdata_en_q), .trap_data_q(trap_data_q), .trap_data_en_q(trap_data_en_q),
		.mcu_reset_q(mcu_reset_q), .user_map_q(user_map_q), .term_txd_q(term_txd_q),
		.host_txd_q(host_txd_q));

	// --------------------------------------------------------------
	// Clock, access tasks and reporting
	// --------------------------------------------------------------
	// Free-running 40 MHz clock.
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		dmmd_mcu_model_inst.access(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [13:0] a);
		dmmd_mcu_model_inst.access(1'b0, 1'b0, a, 8'h00);
	endtask

	task automatic fetch(input logic [13:0] a);
		dmmd_mcu_model_inst.access(1'b0, 1'b1, a, 8'h00);
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// A hang is cut short well beyond the roughly 23100 cycles the tests need.
	initial
	begin
		#1ms;
		mismatches++;
		test_done();
	end

	// --------------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		map_size_jumper = 1'b1;
		write_protect_jumper = 1'b0;
		part_cfg = 2'h0;
		abort_switch = 1'b0;
		user_reset_switch = 1'b0;
		breakpoint_hit = 1'b0;
		term_rxd = 1'b1;
		host_rxd = 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		rd(14'h0050);
		check(rdata_en_q, 1'b1);
		check(rdata_q[0], 1'b0);
		// Host channel at its fastest rate, looped back on itself. This runs before the
		// transparent test so that no stray frame keeps the receiver busy.
		wr(14'h0026, 8'h06);
		wr(14'h0024, 8'hA5);
		repeat (23000) @(posedge core_clk) host_rxd <= host_txd_q;
		rd(14'h0025);
		check(rdata_q[1:0], 2'h3);
		rd(14'h0024);
		check(rdata_q, 8'hA5);
		for (int i = 0; i < 10; i++)
		begin
			rd(mon_a[i]);
			check(sel_q, mon_s[i]);
		end
		wr(14'h0100, 8'hA5);
		rd(14'h0100);
		check(rdata_q, 8'hA5);
		// Transparent mode on channel 0, both directions.
		wr(14'h0022, 8'h08);
		term_rxd <= 1'b0;
		host_rxd <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		check(host_txd_q, 1'b0);
		check(term_txd_q, 1'b0);
		term_rxd <= 1'b1;
		host_rxd <= 1'b1;
		wr(14'h0022, 8'h00);
		// Temporary switch: fetch and two operands in monitor, one user access.
		wr(14'h0050, 8'h02);
		fetch(14'h0180);
		check(sel_q, 10'h010);
		rd(14'h0050);
		rd(14'h0050);
		check(sel_q, 10'h080);
		rd(14'h0050);
		check(sel_q, 10'h008);
		rd(14'h0050);
		check(sel_q, 10'h080);
		// Permanent switch takes effect after the next opcode fetch.
		wr(14'h0050, 8'h01);
		fetch(14'h0180);
		check(user_map_q, 1'b1);
		for (int i = 0; i < 9; i++)
		begin
			if (i == 5)
			begin
				map_size_jumper <= 1'b0;
				part_cfg <= 2'h2;
			end
			rd(usr_a[i]);
			check(sel_q, usr_s[i]);
		end
		map_size_jumper <= 1'b1;
		part_cfg <= 2'h0;
		write_protect_jumper <= 1'b1;
		wr(14'h0180, 8'h55);
		check(prom_we_q, 1'b0);
		write_protect_jumper <= 1'b0;
		wr(14'h0180, 8'h55);
		check(prom_we_q, 1'b1);
		// User code begins at 0180; a plain fetch causes no trap.
		fetch(14'h0180);
		check(trap_data_en_q, 1'b0);
		check(user_map_q, 1'b1);
		abort_switch <= 1'b1;
		fetch(14'h0180);
		check(trap_data_en_q, 1'b1);
		check(trap_data_q, 8'h83);
		abort_switch <= 1'b0;
		repeat (5) wr(14'h00F0, 8'h00);
		check(user_map_q, 1'b0);
		rd(14'h0050);
		check(rdata_q & 8'h21, 8'h20);
		@(posedge core_clk);
		user_reset_switch <= 1'b1;
		@(posedge core_clk);
		user_reset_switch <= 1'b0;
		#1;
		check(mcu_reset_q, 1'b1);
		check(user_map_q, 1'b1);
		test_done();
	end
endmodule // dual_memory_map_decoder_tb_top

`default_nettype wire
